//--- core/urx_pkg.sv
// urx_pkg: constants and types for the serial receive block
// What this block does
// - rx_complete_flag high exactly while buffer holds data
// - clearing receiver_enable empties the receive buffer
// - irq while flag, rx_done_irq_enable, global enable
// - errors stored per character; data read advances
// - error flag positions ignore software writes
// - error flags never raise an interrupt
// - frame_error_flag shows next frame's first stop
// - only first stop bit checked, two_stop_bits_sel ignored
// - overrun on start with buffer and shifter full
// - overrun cleared when frame enters the buffer
// - parity_error_flag zero while parity checking disabled
// - parity_enable enables checker, parity_odd_sel picks type
// - compare computed parity with received bit, buffer it
// - parity_error_flag valid until receive_data_reg read
// - disable is immediate, frame abandoned, pin released
// - sixteen samples per bit, eight in double speed
// - falling edge on idle line starts, sample one
// - vote samples 8-10 or 4-6, high rejects
// - valid start resynchronises counter every frame
// - each bit is majority of three centre samples
// - zero voted stop bit sets frame error
// - unused high data bits read as zero
// - ninth bit buffered, shown in rx_ninth_bit
package urx_pkg;
  localparam logic [1:0] ADDR_STATUS_CTRL_A = 2'h0;
  localparam logic [1:0] ADDR_STATUS_CTRL_B = 2'h1;
  localparam logic [1:0] ADDR_STATUS_CTRL_C = 2'h2;
  localparam logic [1:0] ADDR_RECEIVE_DATA = 2'h3;
  // status_ctrl_a
  localparam int A_RXC_BIT = 7;
  localparam int A_FE_BIT = 4;
  localparam int A_DOR_BIT = 3;
  localparam int A_PE_BIT = 2;
  localparam int A_U2X_BIT = 1;
  // status_ctrl_b
  localparam int B_RX_DONE_IRQ_ENABLE_BIT = 7;
  localparam int B_RECEIVER_ENABLE_BIT = 4;
  localparam int B_NINTH_BIT = 1;
  // status_ctrl_c
  localparam int C_PAR_EN_BIT = 5;
  localparam int C_PAR_ODD_BIT = 4;
  localparam int C_STOP2_BIT = 3;
  localparam int C_SIZE_LSB = 0;
  localparam logic [7:0] CTRL_A_RESET = 8'h00;
  localparam logic [7:0] CTRL_B_RESET = 8'h00;
  localparam logic [7:0] CTRL_C_RESET = 8'h06;
  localparam logic [2:0] SIZE_NINE = 3'h7;
  localparam logic [3:0] SAMPLES_NORMAL = 4'hF;
  localparam logic [3:0] SAMPLES_DOUBLE = 4'h7;
  localparam logic [3:0] VOTE_FIRST_NORMAL = 4'h8;
  localparam logic [3:0] VOTE_FIRST_DOUBLE = 4'h4;
  localparam int BUF_DEPTH = 2;

  typedef struct packed {
    logic [1:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } urx_bus_req_type;

  typedef struct packed {
    logic [8:0] data;
    logic fe;
    logic overrun_flag;
    logic pe;
  } urx_entry_type;

  typedef enum logic [2:0] {
    URX_IDLE = 3'b000,
    URX_START = 3'b001,
    URX_DATA = 3'b010,
    URX_PARITY = 3'b011,
    URX_STOP = 3'b100
  } urx_state_type;
endpackage

//--- core/urx_receiver.sv
// urx_receiver: receive half of a serial port with two-entry buffer
//
// Implementation choices: the register offsets and the address-and-strobe port.
module urx_receiver
  import urx_pkg::*;
(
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic clk_en,
  input wire logic sample_tick,
  input wire logic serial_in,
  input wire logic global_irq_en,
  input wire urx_bus_req_type bus_req,
  output logic [7:0] rdata,
  output logic rx_irq,
  output logic rx_pin_override
);
  logic [7:0] ctrl_a_q;
  logic [7:0] ctrl_b_q;
  logic [7:0] ctrl_c_q;
  logic [7:0] rdata_q;
  urx_state_type state_q;
  urx_state_type state_d;
  logic [3:0] smp_q;
  logic [3:0] smp_d;
  logic [3:0] bit_idx_q;
  logic [3:0] bit_idx_d;
  logic [1:0] vote_q;
  logic [8:0] shift_q;
  logic par_bit_q;
  logic line_prev_q;
  urx_entry_type buf_q [BUF_DEPTH];
  logic rd_ptr_q;
  logic [1:0] count_q;
  urx_entry_type wait_q;
  logic wait_full_q;
  logic dor_pend_q;

  // control fields
  wire rx_en = ctrl_b_q[B_RECEIVER_ENABLE_BIT];
  wire rx_done_irq_enable = ctrl_b_q[B_RX_DONE_IRQ_ENABLE_BIT];
  wire dbl = ctrl_a_q[A_U2X_BIT];
  wire par_en = ctrl_c_q[C_PAR_EN_BIT];
  wire par_odd = ctrl_c_q[C_PAR_ODD_BIT];
  wire [2:0] size_sel = ctrl_c_q[C_SIZE_LSB +: 3];
  wire [3:0] nbits = (size_sel == SIZE_NINE) ? 4'h9 :
                     (size_sel[2] ? 4'h8 : 4'h5 + {1'b0, size_sel});

  // bus decode
  wire wr_a = bus_req.wr && bus_req.addr == ADDR_STATUS_CTRL_A;
  wire wr_b = bus_req.wr && bus_req.addr == ADDR_STATUS_CTRL_B;
  wire wr_c = bus_req.wr && bus_req.addr == ADDR_STATUS_CTRL_C;
  wire rd_data = bus_req.rd && bus_req.addr == ADDR_RECEIVE_DATA;

  // sampling position; counter holds sample number minus one
  wire [3:0] last_smp = dbl ? SAMPLES_DOUBLE : SAMPLES_NORMAL;
  wire [3:0] vote_pos = dbl ? VOTE_FIRST_DOUBLE : VOTE_FIRST_NORMAL;
  wire at_v0 = smp_q == vote_pos - 4'h1;
  wire at_v1 = smp_q == vote_pos;
  wire at_dec = smp_q == vote_pos + 4'h1;
  wire at_end = smp_q == last_smp;
  wire busy = state_q != URX_IDLE;
  wire tick = clk_en && sample_tick && rx_en;
  wire decide = tick && busy && at_dec;
  // two or three high samples give one
  wire maj = (vote_q[0] & vote_q[1]) | (vote_q[0] & serial_in) | (vote_q[1] & serial_in);

  wire start_edge = tick && !busy && line_prev_q && !serial_in;
  wire start_ok = decide && state_q == URX_START && !maj;
  wire frame_done = decide && state_q == URX_STOP;

  // buffer
  wire [1:0] depth = 2'(BUF_DEPTH);
  wire pop = clk_en && rd_data && count_q != 2'h0;
  wire room = count_q != depth || pop;
  wire overrun = start_ok && wait_full_q && !room;
  wire push_wait = wait_full_q && room;
  wire push_new = frame_done && !wait_full_q && room;
  wire hold_new = frame_done && !wait_full_q && !room;
  wire push = clk_en && rx_en && (push_wait || push_new);
  wire wr_ptr = rd_ptr_q ^ count_q[0];
  wire [8:0] data_fin = par_en ? shift_q : shift_q;
  wire par_err = par_en && (^shift_q ^ par_bit_q ^ par_odd);
  urx_entry_type new_entry;
  assign new_entry = '{data: data_fin, fe: !maj, overrun_flag: dor_pend_q, pe: par_err};
  wire urx_entry_type push_entry = push_wait ? wait_q : new_entry;
  wire urx_entry_type head = buf_q[rd_ptr_q];
  wire rx_complete_flag = count_q != 2'h0;

  // readable views; error bits only come from the buffer head
  wire [7:0] view_a = {rx_complete_flag, 2'b00, rx_complete_flag && head.fe, rx_complete_flag && head.overrun_flag, rx_complete_flag && head.pe, dbl, 1'b0};
  wire [7:0] view_b = {ctrl_b_q[7:2], rx_complete_flag && head.data[8], 1'b0};
  wire [7:0] view_d = rx_complete_flag ? head.data[7:0] : 8'h00;
  wire [7:0] rd_mux = (bus_req.addr == ADDR_STATUS_CTRL_A) ? view_a :
                      (bus_req.addr == ADDR_STATUS_CTRL_B) ? view_b :
                      (bus_req.addr == ADDR_STATUS_CTRL_C) ? ctrl_c_q : view_d;

  assign rdata = rdata_q;
  assign rx_irq = rx_complete_flag && rx_done_irq_enable && global_irq_en;
  assign rx_pin_override = rx_en;

  // receive sequencer
  always_comb begin
    state_d = state_q;
    smp_d = smp_q;
    bit_idx_d = bit_idx_q;
    if (start_edge) begin
      state_d = URX_START;
      // this tick was sample one, so the next tick is sample two
      smp_d = 4'h1;
      bit_idx_d = 4'h0;
    end else if (tick && busy) begin
      smp_d = at_end ? 4'h0 : smp_q + 4'h1;
      unique case (state_q)
        URX_START: begin
          if (decide && maj) begin
            state_d = URX_IDLE;
          end else if (at_end) begin
            state_d = URX_DATA;
          end
        end
        URX_DATA: begin
          if (decide) begin
            bit_idx_d = bit_idx_q + 4'h1;
          end
          if (at_end && bit_idx_q == nbits) begin
            state_d = par_en ? URX_PARITY : URX_STOP;
          end
        end
        URX_PARITY: begin
          if (at_end) begin
            state_d = URX_STOP;
          end
        end
        URX_STOP: begin
          // next start may begin right after the stop vote
          if (decide) begin
            state_d = URX_IDLE;
          end
        end
        default: begin
          state_d = URX_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= URX_IDLE;
      smp_q <= 4'h0;
      bit_idx_q <= 4'h0;
      line_prev_q <= 1'b1;
    end else if (clk_en) begin
      if (!rx_en) begin
        state_q <= URX_IDLE;
        smp_q <= 4'h0;
        bit_idx_q <= 4'h0;
        line_prev_q <= 1'b1;
      end else begin
        state_q <= state_d;
        smp_q <= smp_d;
        bit_idx_q <= bit_idx_d;
        if (sample_tick) begin
          line_prev_q <= serial_in;
        end
      end
    end
  end

  // sample collection and bit capture
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      vote_q <= 2'b00;
      shift_q <= 9'h000;
      par_bit_q <= 1'b0;
    end else if (clk_en) begin
      if (start_edge) begin
        shift_q <= 9'h000;
      end
      if (tick && busy && at_v0) begin
        vote_q[0] <= serial_in;
      end
      if (tick && busy && at_v1) begin
        vote_q[1] <= serial_in;
      end
      if (decide && state_q == URX_DATA && bit_idx_q < 4'h9) begin
        shift_q[bit_idx_q] <= maj;
      end
      if (decide && state_q == URX_PARITY) begin
        par_bit_q <= maj;
      end
    end
  end

  // two-entry buffer, waiting frame and overrun
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rd_ptr_q <= 1'b0;
      count_q <= 2'h0;
      wait_full_q <= 1'b0;
      dor_pend_q <= 1'b0;
      wait_q <= '0;
      buf_q[0] <= '0;
      buf_q[1] <= '0;
    end else if (clk_en) begin
      if (!rx_en) begin
        rd_ptr_q <= 1'b0;
        count_q <= 2'h0;
        wait_full_q <= 1'b0;
        dor_pend_q <= 1'b0;
      end else begin
        if (push) begin
          buf_q[wr_ptr] <= push_entry;
        end
        if (pop) begin
          rd_ptr_q <= ~rd_ptr_q;
        end
        count_q <= count_q + {1'b0, push} - {1'b0, pop};
        if (hold_new) begin
          wait_q <= new_entry;
          wait_full_q <= 1'b1;
        end else if (push_wait || overrun) begin
          wait_full_q <= 1'b0;
        end
        if (overrun) begin
          dor_pend_q <= 1'b1;
        end else if (push) begin
          dor_pend_q <= 1'b0;
        end
      end
    end
  end

  // register port; error positions of status_ctrl_a are not writable
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_a_q <= CTRL_A_RESET;
      ctrl_b_q <= CTRL_B_RESET;
      ctrl_c_q <= CTRL_C_RESET;
      rdata_q <= 8'h00;
    end else if (clk_en) begin
      if (wr_a) begin
        ctrl_a_q[A_U2X_BIT] <= bus_req.wdata[A_U2X_BIT];
      end
      if (wr_b) begin
        ctrl_b_q <= {bus_req.wdata[7:2], 2'b00};
      end
      if (wr_c) begin
        ctrl_c_q <= bus_req.wdata;
      end
      rdata_q <= bus_req.rd ? rd_mux : 8'h00;
    end
  end

  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);

  sequence s_start_seen;
    start_edge;
  endsequence
  sequence s_rejected;
    decide && state_q == URX_START && maj;
  endsequence

  property p_rxc_after_push;
    (push && count_q == 2'h0 && !pop) |=> rx_complete_flag && view_a[A_RXC_BIT];
  endproperty
  a_rxc_after_push: assert property (p_rxc_after_push) else $error("flag not set after push");

  property p_flush;
    (clk_en && !rx_en) |=> count_q == 2'h0 && !rx_irq;
  endproperty
  a_flush: assert property (p_flush) else $error("buffer not flushed on disable");

  property p_irq_cause;
    rx_irq |-> rx_complete_flag && rx_done_irq_enable && global_irq_en && count_q != 2'h0;
  endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("interrupt without cause");

  property p_read_advance;
    (pop && !push && count_q == 2'h2) |=> count_q == 2'h1 && rd_ptr_q != $past(rd_ptr_q);
  endproperty
  a_read_advance: assert property (p_read_advance) else $error("data read did not advance");

  property p_err_ro;
    (clk_en && wr_a && !push && !pop && rx_en) |=> $stable(view_a[A_FE_BIT:A_PE_BIT]);
  endproperty
  a_err_ro: assert property (p_err_ro) else $error("error flags changed by write");

  property p_parity_off;
    (push_new && !par_en) |=> !buf_q[$past(wr_ptr)].pe;
  endproperty
  a_parity_off: assert property (p_parity_off) else $error("parity error with checking off");

  property p_overrun_clear;
    (push && !overrun && rx_en) |=> !dor_pend_q;
  endproperty
  a_overrun_clear: assert property (p_overrun_clear) else $error("overrun not cleared");

  property p_overrun_set;
    overrun |=> dor_pend_q && !wait_full_q;
  endproperty
  a_overrun_set: assert property (p_overrun_set) else $error("overrun not raised");

  property p_start_reject;
    s_rejected |=> state_q == URX_IDLE;
  endproperty
  a_start_reject: assert property (p_start_reject) else $error("noisy start not rejected");

  property p_start_count;
    s_start_seen |=> state_q == URX_START && smp_q == 4'h1;
  endproperty
  a_start_count: assert property (p_start_count) else $error("start did not resync counter");

  property p_sample_range;
    busy |-> smp_q <= last_smp;
  endproperty
  a_sample_range: assert property (p_sample_range) else $error("sample counter out of range");
endmodule

//--- verif/urx_tx_model.sv
// urx_tx_model: remote serial transmitter driving the receive line
module urx_tx_model (
  input wire logic mclk,
  input wire logic sample_tick,
  input wire logic dbl,
  output logic serial_in
);
  timeunit 1ns;
  timeprecision 1ns;
  initial serial_in = 1'b1;
  // bounded so a stalled tick cannot hang the model
  task automatic tick();
    for (int k = 0; k < 8; k++) begin
      @(posedge mclk);
      if (sample_tick === 1'b1) break;
    end
  endtask
  // f holds start, data lsb first, optional parity and stop, in that order
  task automatic send(input logic [12:0] f, input int n);
    for (int i = 0; i < n; i++) begin
      tick();
      serial_in <= f[i];
      repeat ((dbl ? 8 : 16) - 1) tick();
    end
    tick();
    serial_in <= 1'b1;
  endtask
  // short low pulse, then idle long enough for the receiver to give up
  task automatic glitch(input int n);
    tick();
    serial_in <= 1'b0;
    repeat (n) tick();
    serial_in <= 1'b1;
    repeat (40) tick();
  endtask
endmodule

//--- verif/urx_receiver_tb_top.sv
// urx_receiver_tb_top: self-checking bench for the serial receive block
module urx_receiver_tb_top
  import urx_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {
    logic [7:0] c;
    logic [8:0] d;
    int nb;
    logic pb;
    logic stp;
    logic [7:0] a;
    logic [7:0] q;
    logic [7:0] b;
  } urx_row_type;
  logic mclk;
  logic arst_n;
  logic sample_tick = 1'b0;
  logic serial_in;
  logic dbl;
  logic global_irq_en;
  urx_bus_req_type bus_req;
  logic [7:0] rdata;
  logic rx_irq;
  logic rx_pin_override;
  int failures;
  int n_tests;
  urx_row_type rows [10] = '{
    '{8'h06, 9'h0A5, 8, 1'b0, 1'b1, 8'h80, 8'hA5, 8'h10},
    '{8'h06, 9'h0A5, 8, 1'b0, 1'b0, 8'h90, 8'hA5, 8'h10},
    '{8'h0E, 9'h03C, 8, 1'b0, 1'b0, 8'h90, 8'h3C, 8'h10},
    '{8'h26, 9'h0A5, 8, 1'b0, 1'b1, 8'h80, 8'hA5, 8'h10},
    '{8'h26, 9'h0A5, 8, 1'b1, 1'b1, 8'h84, 8'hA5, 8'h10},
    '{8'h36, 9'h0A5, 8, 1'b1, 1'b1, 8'h80, 8'hA5, 8'h10},
    '{8'h36, 9'h0A5, 8, 1'b0, 1'b1, 8'h84, 8'hA5, 8'h10},
    '{8'h16, 9'h0A5, 8, 1'b1, 1'b1, 8'h80, 8'hA5, 8'h10},
    '{8'h00, 9'h0FF, 5, 1'b0, 1'b1, 8'h80, 8'h1F, 8'h10},
    '{8'h07, 9'h1A5, 9, 1'b0, 1'b1, 8'h80, 8'hA5, 8'h12}
  };

  urx_receiver u_urx_receiver (
    .mclk(mclk),
    .arst_n(arst_n),
    .clk_en(1'b1),
    .sample_tick(sample_tick),
    .serial_in(serial_in),
    .global_irq_en(global_irq_en),
    .bus_req(bus_req),
    .rdata(rdata),
    .rx_irq(rx_irq),
    .rx_pin_override(rx_pin_override)
  );
  urx_tx_model u_urx_tx_model (
    .mclk(mclk),
    .sample_tick(sample_tick),
    .dbl(dbl),
    .serial_in(serial_in)
  );

  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  // two system clocks per sample keeps frames short
  always @(posedge mclk) begin
    sample_tick <= ~sample_tick;
  end

  task automatic tally_and_finish();
    if (failures == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [1:0] a, input logic [7:0] v);
    @(posedge mclk);
    bus_req <= '{a, v, 1'b1, 1'b0};
    @(posedge mclk);
    bus_req <= '0;
  endtask
  task automatic rd(input logic [1:0] a, input logic [7:0] e);
    @(posedge mclk);
    bus_req <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge mclk);
    bus_req <= '0;
    @(negedge mclk);
    chk(rdata, e);
  endtask
  task automatic tx(input logic [7:0] c, input logic [8:0] d, input int nb, input logic pb, input logic stp);
    logic [12:0] f;
    int n;
    f = '1;
    f[0] = 1'b0;
    for (int i = 0; i < nb; i++) f[i + 1] = d[i];
    n = nb + 1;
    if (c[5]) begin
      f[n] = pb;
      n++;
    end
    f[n] = stp;
    u_urx_tx_model.send(f, n + 1);
  endtask

  initial begin
    repeat (100000) @(posedge mclk);
    failures++;
    tally_and_finish();
  end

  initial begin
    failures = 0;
    n_tests = 0;
    arst_n = 1'b0;
    bus_req = '0;
    global_irq_en = 1'b0;
    dbl = 1'b0;
    repeat (12) @(posedge mclk);
    arst_n <= 1'b1;
    @(negedge mclk);
    chk({7'h00, rx_pin_override}, 8'h00);
    rd(2'h2, 8'h06);
    rd(2'h1, 8'h00);
    rd(2'h0, 8'h00);
    wr(2'h1, 8'h10);
    @(negedge mclk);
    chk({7'h00, rx_pin_override}, 8'h01);
    foreach (rows[i]) begin
      wr(2'h2, rows[i].c);
      tx(rows[i].c, rows[i].d, rows[i].nb, rows[i].pb, rows[i].stp);
      rd(2'h0, rows[i].a);
      chk({7'h00, rx_irq}, 8'h00);
      rd(2'h1, rows[i].b);
      rd(2'h3, rows[i].q);
      rd(2'h0, 8'h00);
    end
    wr(2'h2, 8'h06);
    wr(2'h1, 8'h90);
    global_irq_en <= 1'b1;
    tx(8'h06, 9'h055, 8, 1'b0, 1'b1);
    @(negedge mclk);
    chk({7'h00, rx_irq}, 8'h01);
    @(posedge mclk);
    global_irq_en <= 1'b0;
    @(negedge mclk);
    chk({7'h00, rx_irq}, 8'h00);
    global_irq_en <= 1'b1;
    rd(2'h3, 8'h55);
    chk({7'h00, rx_irq}, 8'h00);
    wr(2'h1, 8'h10);
    // three frames fill buffer and shifter; the fourth start loses one
    tx(8'h06, 9'h011, 8, 1'b0, 1'b1);
    tx(8'h06, 9'h022, 8, 1'b0, 1'b1);
    tx(8'h06, 9'h033, 8, 1'b0, 1'b1);
    tx(8'h06, 9'h044, 8, 1'b0, 1'b1);
    rd(2'h0, 8'h80);
    rd(2'h3, 8'h11);
    rd(2'h0, 8'h80);
    rd(2'h3, 8'h22);
    rd(2'h0, 8'h88);
    rd(2'h3, 8'h44);
    rd(2'h0, 8'h00);
    tx(8'h06, 9'h055, 8, 1'b0, 1'b1);
    rd(2'h0, 8'h80);
    rd(2'h3, 8'h55);
    tx(8'h06, 9'h066, 8, 1'b0, 1'b1);
    fork
      tx(8'h06, 9'h077, 8, 1'b0, 1'b1);
      begin
        repeat (60) @(posedge mclk);
        wr(2'h1, 8'h00);
      end
    join
    @(negedge mclk);
    chk({7'h00, rx_pin_override}, 8'h00);
    wr(2'h1, 8'h10);
    rd(2'h0, 8'h00);
    u_urx_tx_model.glitch(7);
    rd(2'h0, 8'h00);
    tx(8'h06, 9'h05A, 8, 1'b0, 1'b1);
    rd(2'h0, 8'h80);
    rd(2'h3, 8'h5A);
    // error positions written as ones on purpose to see them refused
    wr(2'h0, 8'h9E);
    rd(2'h0, 8'h02);
    dbl <= 1'b1;
    tx(8'h06, 9'h0A3, 8, 1'b0, 1'b1);
    rd(2'h0, 8'h82);
    rd(2'h3, 8'hA3);
    u_urx_tx_model.glitch(3);
    rd(2'h0, 8'h02);
    wr(2'h0, 8'h00);
    dbl <= 1'b0;
    rd(2'h0, 8'h00);
    tally_and_finish();
  end
endmodule
